// [hdl/adc_out_pkg.sv]
package adc_out_pkg;

   localparam int SYS_CLK_HZ = 200_000_000;

   // Output word layout.
   localparam int WORD_W   = 24;
   localparam int IN_W     = 22;
   localparam int EOC_BIT  = 23;
   localparam int FILL_BIT = 22;
   localparam int SIGN_BIT = 21;
   localparam int MAG_MSB  = 20;

   // Clamp limits in result steps: +FS and -FS-1.
   localparam logic signed [IN_W-1:0] FS_POS       = 22'sh100000;
   localparam logic signed [IN_W-1:0] FS_NEG_CLAMP = 22'sh2FFFFF;

   // Falls already counted when the 24th serial clock falls.
   localparam logic [4:0] LAST_FALL = 5'h17;

   // Self-clocked serial clock: conversion clock divided by eight.
   localparam int         SCK_DIV       = 8;
   localparam logic [1:0] SCK_HALF_LAST = 2'(SCK_DIV / 2 - 1);

   // External conversion clock detection and notch placement.
   localparam int EXT_MIN_HZ      = 5000;
   localparam int EXT_TIMEOUT_CYC = SYS_CLK_HZ / EXT_MIN_HZ;
   localparam int NOTCH_DIV       = 2560;
   localparam int NOTCH60_HZ      = 60;
   localparam int NOTCH50_HZ      = 50;

   localparam logic [10:0] INT60_LAST =
      11'(SYS_CLK_HZ / (NOTCH60_HZ * NOTCH_DIV) - 1);
   localparam logic [10:0] INT50_LAST =
      11'(SYS_CLK_HZ / (NOTCH50_HZ * NOTCH_DIV) - 1);
   localparam logic [11:0] NOTCH_LAST = 12'(NOTCH_DIV - 1);

   typedef enum logic [1:0] {ST_CONV, ST_SLEEP, ST_OUT} state_e;

endpackage

// [hdl/rate_clock_detect.sv]
`timescale 1ns/1ps
module rate_clock_detect #(
   parameter int TIMEOUT_CYC = adc_out_pkg::EXT_TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic arst_n_in,
   // Rate pin
   input  wire logic rate_select_clock_pin_in,
   // Conversion clock status
   output logic      ext_clk_out,
   output logic      notch_50hz_out,
   output logic      conv_tick_out,
   output logic      notch_tick_out
);
   import adc_out_pkg::*;

   localparam logic [15:0] GAP_TOP = 16'(TIMEOUT_CYC);

   logic        pin_s1_q;
   logic        pin_s2_q;
   logic        pin_prev_q;
   logic [15:0] gap_q, gap_d;
   logic        ext_q, ext_d;
   logic        sel50_q, sel50_d;
   logic [10:0] div_q, div_d;
   logic        tick_q, tick_d;
   logic [11:0] ntc_q, ntc_d;
   logic        ntick_q, ntick_d;
   logic        rise;
   logic [10:0] div_last;

   always_comb begin
      rise     = pin_s2_q & ~pin_prev_q;
      gap_d    = (gap_q == GAP_TOP) ? gap_q : gap_q + 16'h1;
      ext_d    = ext_q;
      sel50_d  = sel50_q;
      if (rise) begin
         gap_d = 16'h0;
      end
      // A second edge inside the window proves a running clock.
      if (rise && gap_q != GAP_TOP) begin
         ext_d = 1'b1; // [RL18]
      end else if (gap_q == GAP_TOP) begin
         ext_d   = 1'b0;     // [RL20]
         sel50_d = pin_s2_q; // [RL16]
      end
      // Switching the limit mid-count only stretches or shortens one period.
      div_last = sel50_q ? INT50_LAST : INT60_LAST; // [RL17] [RL21]
      div_d    = 11'h0;
      tick_d   = 1'b0;
      if (ext_q) begin
         tick_d = rise; // [RL18]
      end else if (div_q >= div_last) begin
         tick_d = 1'b1;
      end else begin
         div_d = div_q + 11'h1;
      end
      ntc_d   = ntc_q;
      ntick_d = 1'b0;
      if (tick_q) begin
         if (ntc_q == NOTCH_LAST) begin
            ntc_d   = 12'h0;
            ntick_d = 1'b1; // [RL19]
         end else begin
            ntc_d = ntc_q + 12'h1;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_s1_q   <= 1'b0;
         pin_s2_q   <= 1'b0;
         pin_prev_q <= 1'b0;
         gap_q      <= GAP_TOP;
         ext_q      <= 1'b0;
         sel50_q    <= 1'b0;
         div_q      <= 11'h0;
         tick_q     <= 1'b0;
         ntc_q      <= 12'h0;
         ntick_q    <= 1'b0;
      end else begin
         pin_s1_q   <= rate_select_clock_pin_in;
         pin_s2_q   <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
         gap_q      <= gap_d;
         ext_q      <= ext_d;
         sel50_q    <= sel50_d;
         div_q      <= div_d;
         tick_q     <= tick_d;
         ntc_q      <= ntc_d;
         ntick_q    <= ntick_d;
      end
   end

   assign ext_clk_out    = ext_q;
   assign notch_50hz_out = sel50_q;
   assign conv_tick_out  = tick_q;
   assign notch_tick_out = ntick_q;

endmodule

// [hdl/adc_result_shifter_clock_select.sv]
`timescale 1ns/1ps
// Behaviour
// RL1: Each output word is 24 bits: three status bits, then 21 result bits.
// RL2: Bit 23 is high while converting and low once conversion ends.
// RL3: In conversion and sleep, data pin shows done flag while select low.
// RL4: Bit 22 is a filler bit, always low.
// RL5: Bit 21 is high for non-negative input, low for negative.
// RL6: Bits 21 and 20 both high on overrange, both low on underrange.
// RL7: Bits 20 down to 0 carry the result, most significant first.
// RL8: Sign with bits 20..0 form one continuous offset code.
// RL9: Clamp to +FS above range and to -FS minus one step below.
// RL10: Select high: data pin released, serial clocks ignored by shifter.
// RL11: Done flag falls on the pin at completion, without clock edges.
// RL12: Host lowers select before applying any serial clock.
// RL13: Host takes bit 23 on first rise; later bits change on falls.
// RL14: Bit 0 leaves on the 23rd fall; host takes it on 24th rise.
// RL15: The 24th fall puts the next cycle's done flag on the pin.
// RL16: Without external clock, rate pin low picks 60 Hz, high 50 Hz.
// RL17: Notch change in sleep or output is harmless.
// RL18: A clock of at least 5 kHz on the rate pin becomes conversion clock.
// RL19: With external clock the notch sits at that frequency over 2560.
// RL20: When the external clock stops, the internal oscillator returns.
// RL21: Clock source change spoils at most the conversion in progress.
// RL22: Source change in self-clocked output keeps the bit stream valid.
// RL23: Select raised after first rise ends output and starts conversion.
// RL24: After all 24 bits, output ends and a new conversion starts.
// RL25: Serial clock pin sampled at power-up and select fall picks mode.
// RL26: Self-clocked serial clock is the conversion clock divided by 8.
// RL27: Finished results arrive in parallel with a strobe and are held.
module adc_result_shifter_clock_select #(
   parameter int EXT_TIMEOUT_CYC = adc_out_pkg::EXT_TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic                            sys_clk_in,
   input  wire logic                            arst_n_in,
   // Serial interface pins
   input  wire logic                            cs_n_in,
   input  wire logic                            sck_in,
   output logic                                 sck_out,
   output logic                                 sck_oe_out,
   output logic                                 serial_data_out_out,
   output logic                                 serial_data_out_oe_out,
   // Rate select pin
   input  wire logic                            rate_select_clock_pin_in,
   // Converter core
   input  wire logic signed [adc_out_pkg::IN_W-1:0] result_in,
   input  wire logic                            result_valid_in,
   output logic                                 conv_start_out,
   output logic                                 converting_out,
   // Conversion clock status and serial clock mode
   output logic                                 ext_clk_out,
   output logic                                 notch_50hz_out,
   output logic                                 conv_tick_out,
   output logic                                 notch_tick_out,
   output logic                                 ext_sck_mode_out
);
   import adc_out_pkg::*;

   // Pin synchronisers.
   logic cs_s1_q;
   logic cs_s2_q;
   logic cs_prev_q;
   logic sck_s1_q;
   logic sck_s2_q;
   logic sck_prev_q;

   // Transfer control.
   state_e              state_q, state_d;
   logic [WORD_W-1:0]   word_q, word_d;
   logic [4:0]          fall_cnt_q, fall_cnt_d;
   logic                seen_rise_q, seen_rise_d;
   logic                ext_sck_q, ext_sck_d;
   logic                strap_done_q, strap_done_d;
   logic [1:0]          strap_wait_q, strap_wait_d;
   logic                conv_start_q, conv_start_d;

   // Self-generated serial clock.
   logic [1:0]          sck_div_q, sck_div_d;
   logic                sck_q, sck_d;

   // Pin drivers.
   logic                sdo_q, sdo_d;
   logic                sdo_oe_q, sdo_oe_d;
   logic                sck_oe_q, sck_oe_d;
   logic                converting_q, converting_d;

   logic                conv_tick;
   logic                cs_fall;
   logic                cs_rise;
   logic                ext_rise;
   logic                ext_fall;
   logic                int_toggle;
   logic                rise_ev;
   logic                fall_ev;

   function automatic logic [WORD_W-1:0] fmt(
      input logic signed [IN_W-1:0] v
   );
      logic signed [IN_W-1:0] c;
      c = v;
      if (v > FS_POS) begin
         c = FS_POS; // [RL9] [RL6]
      end else if (v < FS_NEG_CLAMP) begin
         c = FS_NEG_CLAMP; // [RL9] [RL6]
      end
      // Inverting the two's complement sign gives the offset code.
      fmt = {2'h0, ~c[SIGN_BIT], c[MAG_MSB:0]}; // [RL4] [RL5] [RL7] [RL8]
   endfunction

   rate_clock_detect #(
      .TIMEOUT_CYC (EXT_TIMEOUT_CYC)
   ) u_rate (
      .sys_clk_in               (sys_clk_in),
      .arst_n_in                (arst_n_in),
      .rate_select_clock_pin_in (rate_select_clock_pin_in),
      .ext_clk_out              (ext_clk_out),
      .notch_50hz_out           (notch_50hz_out),
      .conv_tick_out            (conv_tick),
      .notch_tick_out           (notch_tick_out)
   );

   assign conv_tick_out = conv_tick;

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cs_s1_q    <= 1'b1;
         cs_s2_q    <= 1'b1;
         cs_prev_q  <= 1'b1;
         sck_s1_q   <= 1'b1;
         sck_s2_q   <= 1'b1;
         sck_prev_q <= 1'b1;
      end else begin
         cs_s1_q    <= cs_n_in;
         cs_s2_q    <= cs_s1_q;
         cs_prev_q  <= cs_s2_q;
         sck_s1_q   <= sck_in;
         sck_s2_q   <= sck_s1_q;
         sck_prev_q <= sck_s2_q;
      end
   end

   // Edges of both serial clock sources reduced to one pair of events.
   always_comb begin
      cs_fall    = cs_prev_q & ~cs_s2_q;
      cs_rise    = ~cs_prev_q & cs_s2_q;
      ext_rise   = sck_s2_q & ~sck_prev_q;
      ext_fall   = ~sck_s2_q & sck_prev_q;
      int_toggle = (state_q == ST_OUT) && !ext_sck_q && conv_tick &&
                   (sck_div_q == SCK_HALF_LAST);
      rise_ev    = ext_sck_q ? ext_rise : (int_toggle & ~sck_q);
      fall_ev    = ext_sck_q ? ext_fall : (int_toggle & sck_q);
   end

   // The divider follows whichever conversion clock is active, so a source
   // change only alters the period of the clock, never the bit order.
   always_comb begin
      sck_div_d = 2'h0;
      sck_d     = 1'b1;
      if (state_q == ST_OUT && !ext_sck_q) begin
         sck_div_d = sck_div_q;
         sck_d     = sck_q;
         if (conv_tick) begin
            if (sck_div_q == SCK_HALF_LAST) begin
               sck_div_d = 2'h0;
               sck_d     = ~sck_q; // [RL26] [RL22]
            end else begin
               sck_div_d = sck_div_q + 2'h1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sck_div_q <= 2'h0;
         sck_q     <= 1'b1;
      end else begin
         sck_div_q <= sck_div_d;
         sck_q     <= sck_d;
      end
   end

   always_comb begin
      state_d      = state_q;
      word_d       = word_q;
      fall_cnt_d   = fall_cnt_q;
      seen_rise_d  = seen_rise_q;
      ext_sck_d    = ext_sck_q;
      strap_wait_d = {strap_wait_q[0], 1'b1};
      strap_done_d = strap_done_q | strap_wait_q[1];
      conv_start_d = 1'b0;
      // An idle pulled-up pin reads high, which selects self clocking.
      // The strap waits until the synchroniser carries the real pin level,
      // as its reset value would always pick self clocking.
      if (!strap_done_q) begin
         if (strap_wait_q[1]) begin
            ext_sck_d    = ~sck_s2_q; // [RL25]
            conv_start_d = 1'b1;
         end
      end else if (cs_fall) begin
         ext_sck_d = ~sck_s2_q; // [RL25]
      end
      case (state_q)
         ST_CONV: begin
            if (result_valid_in) begin
               word_d  = fmt(result_in); // [RL27] [RL1]
               state_d = ST_SLEEP;       // [RL11]
            end
         end
         ST_SLEEP: begin
            // The held word waits here until select goes low.
            if (!cs_s2_q) begin
               state_d     = ST_OUT; // [RL12]
               fall_cnt_d  = 5'h0;
               seen_rise_d = 1'b0;
            end
         end
         ST_OUT: begin
            if (cs_s2_q) begin
               if (seen_rise_q) begin
                  state_d      = ST_CONV; // [RL23]
                  conv_start_d = 1'b1;
               end else begin
                  state_d = ST_SLEEP;
               end
            end else begin
               if (rise_ev) begin
                  seen_rise_d = 1'b1; // [RL13]
               end
               // Falls before the first rise are the clock settling low.
               if (fall_ev && seen_rise_q) begin
                  word_d     = word_q << 1; // [RL13] [RL14]
                  fall_cnt_d = fall_cnt_q + 5'h1;
                  if (fall_cnt_q == LAST_FALL) begin
                     state_d      = ST_CONV; // [RL24] [RL15]
                     conv_start_d = 1'b1;
                  end
               end
            end
         end
         default: begin
            state_d = ST_CONV;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q      <= ST_CONV;
         word_q       <= '0;
         fall_cnt_q   <= 5'h0;
         seen_rise_q  <= 1'b0;
         ext_sck_q    <= 1'b0;
         strap_done_q <= 1'b0;
         strap_wait_q <= 2'h0;
         conv_start_q <= 1'b0;
      end else begin
         state_q      <= state_d;
         word_q       <= word_d;
         fall_cnt_q   <= fall_cnt_d;
         seen_rise_q  <= seen_rise_d;
         ext_sck_q    <= ext_sck_d;
         strap_done_q <= strap_done_d;
         strap_wait_q <= strap_wait_d;
         conv_start_q <= conv_start_d;
      end
   end

   // The data pin follows the next state, so the done flag drops in the
   // cycle after completion with no serial clock involved.
   always_comb begin
      if (state_d == ST_OUT) begin
         sdo_d = word_d[EOC_BIT]; // [RL13]
      end else begin
         sdo_d = (state_d == ST_CONV); // [RL2] [RL3] [RL11] [RL15]
      end
      sdo_oe_d     = ~cs_s2_q; // [RL10] [RL3]
      sck_oe_d     = (state_d == ST_OUT) && !ext_sck_d;
      converting_d = (state_d == ST_CONV);
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sdo_q        <= 1'b1;
         sdo_oe_q     <= 1'b0;
         sck_oe_q     <= 1'b0;
         converting_q <= 1'b1;
      end else begin
         sdo_q        <= sdo_d;
         sdo_oe_q     <= sdo_oe_d;
         sck_oe_q     <= sck_oe_d;
         converting_q <= converting_d;
      end
   end

   assign sck_out                = sck_q;
   assign sck_oe_out             = sck_oe_q;
   assign serial_data_out_out    = sdo_q;
   assign serial_data_out_oe_out = sdo_oe_q;
   assign conv_start_out         = conv_start_q;
   assign converting_out         = converting_q;
   assign ext_sck_mode_out       = ext_sck_q;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   chk_pin_released: assert property ( // [RL10]
      $rose(cs_s2_q) |=> !serial_data_out_oe_out ##1 !sck_oe_out)
      else $error("data pin driven with select high");

   chk_status_load: assert property ( // [RL4]
      state_q == ST_CONV && result_valid_in
      |=> word_q[EOC_BIT:FILL_BIT] == 2'h0 && state_q == ST_SLEEP)
      else $error("status bits wrong at load");

   chk_flag_busy: assert property ( // [RL2]
      state_q == ST_CONV && !result_valid_in |=> serial_data_out_out)
      else $error("done flag low during conversion");

   chk_flag_done: assert property ( // [RL11]
      state_q == ST_CONV && result_valid_in
      |=> !serial_data_out_out until_with !cs_s2_q || state_q != ST_SLEEP)
      else $error("done flag not low after completion");

   chk_zero_code: assert property ( // [RL8]
      state_q == ST_CONV && result_valid_in && result_in == 22'sh0
      |=> word_q[SIGN_BIT:0] == 22'h200000)
      else $error("zero input code wrong");

   chk_over_clamp: assert property ( // [RL9]
      state_q == ST_CONV && result_valid_in && result_in > FS_POS
      |=> word_q[SIGN_BIT:0] == 22'h300000)
      else $error("overrange clamp wrong");

   chk_shift_step: assert property ( // [RL13]
      state_q == ST_OUT && !cs_s2_q && fall_ev && seen_rise_q
      |=> word_q == {$past(word_q[WORD_W-2:0]), 1'b0})
      else $error("word did not shift on fall");

   chk_end_word: assert property ( // [RL24]
      state_q == ST_OUT && !cs_s2_q && fall_ev && seen_rise_q &&
      fall_cnt_q == LAST_FALL
      |=> state_q == ST_CONV && conv_start_out && serial_data_out_out)
      else $error("no new conversion after 24 bits");

   chk_early_abort: assert property ( // [RL23]
      state_q == ST_OUT && cs_s2_q && !seen_rise_q
      |=> state_q == ST_SLEEP && !conv_start_out)
      else $error("abort before first rise mishandled");

   chk_mode_sample: assert property ( // [RL25]
      strap_done_q && cs_fall && !sck_s2_q |=> ext_sck_mode_out)
      else $error("serial clock mode not sampled");

endmodule

// [dv/host_mcu_model.sv]
`timescale 1ns/1ps
module host_mcu_model (
   // Clock
   input  wire logic sys_clk_in,
   // Device pins
   input  wire logic sdo_in,
   input  wire logic sdo_oe_in,
   input  wire logic sck_dev_in,
   input  wire logic sck_dev_oe_in,
   output logic      cs_n_out,
   output logic      sck_pin_out
);
   logic sck_drv  = 1'b0;
   logic sck_en   = 1'b1;
   logic sdo_last = 1'b0;
   logic sdo_seen;
   int   rise_gap = 0;

   initial cs_n_out = 1'b1;
   // A released clock pin floats high through its pull-up.
   assign sck_pin_out = sck_dev_oe_in ? sck_dev_in : (sck_en ? sck_drv : 1'b1);
   // A released data pin shows the inverse of the last driven bit.
   assign sdo_seen = sdo_oe_in ? sdo_in : ~sdo_last;
   always @(posedge sys_clk_in) begin
      if (sdo_oe_in)
         sdo_last <= sdo_in;
   end

   task automatic select(input logic ext);
      sck_en <= ext;
      sck_drv <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      cs_n_out <= 1'b0;
      repeat (8) @(posedge sys_clk_in);
   endtask

   task automatic deselect();
      cs_n_out <= 1'b1;
      repeat (8) @(posedge sys_clk_in);
      sck_en <= 1'b1;
      @(posedge sys_clk_in);
   endtask

   task automatic pulse_sck();
      sck_drv <= 1'b1;
      repeat (8) @(posedge sys_clk_in);
      sck_drv <= 1'b0;
      repeat (8) @(posedge sys_clk_in);
   endtask

   task automatic read_ext(input int rises, output logic [23:0] w);
      w = '0;
      select(1'b1);
      for (int i = 0; i < rises; i++) begin
         w[23-i] = sdo_seen;
         pulse_sck();
      end
   endtask

   task automatic read_self(output logic [23:0] w);
      logic prev;
      int   t;
      int   k;
      w = '0;
      prev = 1'b1;
      t = 0;
      k = 0;
      select(1'b0);
      for (int n = 0; n < 20000 && k < 24; n++) begin
         @(posedge sys_clk_in);
         if (sck_pin_out && !prev) begin
            w[23-k] = sdo_seen;
            rise_gap = n - t;
            t = n;
            k++;
         end
         prev = sck_pin_out;
      end
      repeat (64) @(posedge sys_clk_in);
   endtask
endmodule

// [dv/adc_result_shifter_clock_select_tb.sv]
`timescale 1ns/1ps
module adc_result_shifter_clock_select_tb;
   import adc_out_pkg::*;

   logic                   clk        = 1'b0;
   logic                   arst_n     = 1'b0;
   logic                   rate_pin   = 1'b0;
   logic                   ext_on     = 1'b0;
   logic [1:0]             ext_cnt    = 2'h0;
   logic signed [IN_W-1:0] result     = '0;
   logic                   result_vld = 1'b0;
   logic [23:0]            w;
   logic [23:0]            e;
   int                     gap;
   int                     num_errors = 0;
   int                     samples_checked = 0;
   int                     start_count = 0;
   wire logic cs_n, sck_pin, sck_o, sck_oe, serial_data_out, sdo_oe, converting;
   wire logic ext_clk, notch_50, conv_tick, notch_tick, ext_mode, conv_start;

   localparam logic signed [IN_W-1:0] CODES [10] = '{22'sh1FFFFF,
      22'sh100000, 22'sh0FFFFF, 22'sh080000, 22'sh000000, 22'sh3FFFFF,
      22'sh380000, 22'sh300000, 22'sh2FFFFF, 22'sh200000};

   always #2.5 clk = ~clk;

   // External conversion clock of eight system cycles per period.
   always @(posedge clk) begin
      if (ext_on) begin
         ext_cnt <= ext_cnt + 2'h1;
         if (ext_cnt == 2'h3)
            rate_pin <= ~rate_pin;
      end
   end

   // Every conversion request is counted once; the pulse lasts one cycle.
   always @(posedge clk) begin
      if (conv_start === 1'b1)
         start_count++;
   end

   adc_result_shifter_clock_select #(.EXT_TIMEOUT_CYC(64)) i_dut (
      .sys_clk_in(clk), .arst_n_in(arst_n), .cs_n_in(cs_n),
      .sck_in(sck_pin), .sck_out(sck_o), .sck_oe_out(sck_oe),
      .serial_data_out_out(serial_data_out), .serial_data_out_oe_out(sdo_oe),
      .rate_select_clock_pin_in(rate_pin), .result_in(result),
      .result_valid_in(result_vld), .conv_start_out(conv_start),
      .converting_out(converting), .ext_clk_out(ext_clk),
      .notch_50hz_out(notch_50), .conv_tick_out(conv_tick),
      .notch_tick_out(notch_tick), .ext_sck_mode_out(ext_mode));

   host_mcu_model i_host (
      .sys_clk_in(clk), .sdo_in(serial_data_out), .sdo_oe_in(sdo_oe),
      .sck_dev_in(sck_o), .sck_dev_oe_in(sck_oe),
      .cs_n_out(cs_n), .sck_pin_out(sck_pin));

   function automatic logic [23:0] exp_word(input logic signed [21:0] v);
      logic signed [21:0] c;
      c = (v > FS_POS) ? FS_POS : ((v < FS_NEG_CLAMP) ? FS_NEG_CLAMP : v);
      return {2'b00, ~c[21], c[20:0]};
   endfunction

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic convert(input logic signed [IN_W-1:0] v);
      for (int n = 0; n < 4000 && converting !== 1'b1; n++) @(posedge clk);
      repeat (20) @(posedge clk);
      result <= v;
      result_vld <= 1'b1;
      @(posedge clk);
      result_vld <= 1'b0;
      repeat (2) @(posedge clk);
      check(24'(converting), 24'h0);
   endtask

   task automatic tick_gap(output int g);
      for (int n = 0; n < 4000 && conv_tick !== 1'b1; n++) @(posedge clk);
      @(posedge clk);
      g = 1;
      while (conv_tick !== 1'b1 && g < 4000) begin
         @(posedge clk);
         g++;
      end
   endtask

   task automatic notch_count(output int c);
      c = 0;
      for (int n = 0; n < 25000 && notch_tick !== 1'b1; n++) @(posedge clk);
      @(posedge clk);
      for (int n = 0; n < 25000 && notch_tick !== 1'b1; n++) begin
         if (conv_tick === 1'b1)
            c++;
         @(posedge clk);
      end
      if (conv_tick === 1'b1)
         c++;
   endtask

   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      repeat (10) @(posedge clk);
      check(24'(ext_mode), 24'h1);
      check(24'(sdo_oe), 24'h0);
      i_host.select(1'b1);
      check({22'h0, sdo_oe, serial_data_out}, 24'h3);
      convert(CODES[0]);
      check(24'(serial_data_out), 24'h0);
      for (int i = 0; i < 10; i++) begin
         if (i > 0)
            convert(CODES[i]);
         i_host.read_ext(24, w);
         check(w, exp_word(CODES[i]));
         check({22'h0, serial_data_out, converting}, 24'h3);
         i_host.deselect();
         check(24'(sdo_oe), 24'h0);
      end
      // Clocks with select high, then a select pulse with no rise.
      convert(CODES[2]);
      repeat (3) i_host.pulse_sck();
      i_host.read_ext(0, w);
      i_host.deselect();
      check(24'(converting), 24'h0);
      i_host.read_ext(24, w);
      check(w, exp_word(CODES[2]));
      i_host.deselect();
      // Abort after three clocks starts a new conversion.
      convert(CODES[3]);
      e = exp_word(CODES[3]);
      i_host.read_ext(3, w);
      i_host.deselect();
      check({21'h0, w[23:21]}, {21'h0, e[23:21]});
      check(24'(converting), 24'h1);
      tick_gap(gap);
      check(24'(gap), 24'h516);
      rate_pin <= 1'b1;
      repeat (100) @(posedge clk);
      check(24'(notch_50), 24'h1);
      tick_gap(gap);
      tick_gap(gap);
      check(24'(gap), 24'h61A);
      ext_on <= 1'b1;
      repeat (100) @(posedge clk);
      check(24'(ext_clk), 24'h1);
      notch_count(gap);
      check(24'(gap), 24'hA00);
      ext_on <= 1'b0;
      repeat (200) @(posedge clk);
      check(24'(ext_clk), 24'h0);
      // The conversion clock source changes while the word goes out.
      convert(CODES[4]);
      fork
         i_host.read_self(w);
         begin
            repeat (3000) @(posedge clk);
            ext_on <= 1'b1;
         end
      join
      check(w, exp_word(CODES[4]));
      check(24'(ext_mode), 24'h0);
      check(24'(i_host.rise_gap), 24'h40);
      i_host.deselect();
      check(24'(ext_clk), 24'h1);
      check(24'(start_count), 24'hE);
      wrap_up();
   end

   initial begin
      repeat (90000) @(posedge clk);
      num_errors++;
      wrap_up();
   end
endmodule
